// file: core/dcbo_core_end.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Allocated new block filled with zero
// R2 - Allocation may cause delayed machine check
// R3 - Address is base-or-zero plus index
// R4 - Decode flush encoding
// R5 - Decode invalidate encoding
// R6 - Decode store encoding
// R7 - Coherent flush broadcasts address only
// R8 - Flush writes back modified, then invalidates
// R9 - Others write back modified on flush
// R10 - Non-coherent flush local only, no broadcast
// R11 - Flush ignores attributes, checked as load
// R12 - Invalidate discards modified data, no writeback
// R13 - Others invalidate on invalidate broadcast
// R14 - Untranslated invalidate raises data storage
// R15 - Invalidate checked as store, sets R/C
// R16 - Invalidate needs supervisor privilege
// R17 - Clean on unmodified coherent just signals
// R18 - Clean writes back modified block
// R19 - Clean otherwise no local action
// R20 - Load touch no-op when inhibited
// R21 - Store touch no-op when inhibited
// R22 - Touch faults raise no exception
// R23 - Touch may be ignored entirely
module dcbo_core_end #(
  parameter int LINES = 1 << dcbo_pkg::IDX_BITS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic issue,
  input wire logic [31:0] instr,
  input wire logic [31:0] firstIndexReg,
  input wire logic [31:0] secondIndexReg,
  input wire logic coherent,
  input wire logic cacheInhibit,
  input wire logic userMode,
  input wire logic dataTranslationEnable,
  input wire logic xlateHit,
  input wire logic protOk,
  input wire logic busErr,
  output logic busy,
  output logic done,
  output logic dsiExc,
  output logic privExc,
  output logic machineCheck,
  output logic refChgSet,
  dcbo_link_if.core link
);
  import dcbo_pkg::*;
  typedef enum logic [1:0] {DCBO_IDLE, DCBO_WAIT} dcbo_st_t;
  typedef struct packed {
    dcbo_st_t st;
    logic busy;
    logic done;
    logic dsi;
    logic priv;
    logic mchk;
    logic rc;
    logic killAfter;
    logic allocPend;
    logic [IDX_BITS-1:0] allocIdx;
    logic reqValid;
    dcbo_bus_t reqCmd;
    logic [31:0] reqAddr;
    logic reqCoh;
    logic [LINES-1:0] valid;
    logic [LINES-1:0] dirty;
    logic [LINES-1:0][31-BLK_BITS-IDX_BITS:0] tag;
    logic [LINES-1:0][DATA_W-1:0] word0;
  } dcbo_state_t;
  dcbo_state_t cur_ff;
  dcbo_state_t nxt_ff;
  dcbo_op_t op;
  logic [31:0] addr;
  logic [IDX_BITS-1:0] idx;
  logic [31-BLK_BITS-IDX_BITS:0] tg;
  logic hit;
  logic mod;
  logic [IDX_BITS-1:0] reqIdx;
  dcbo_decode u_dec (
    .instr(instr),
    .firstIndexReg(firstIndexReg),
    .secondIndexReg(secondIndexReg),
    .op(op),
    .targetAddr(addr)
  );
  assign idx = addr[BLK_BITS+:IDX_BITS];
  assign tg = addr[31:BLK_BITS+IDX_BITS];
  assign hit = cur_ff.valid[idx] && (cur_ff.tag[idx] == tg);
  assign mod = hit && cur_ff.dirty[idx];
  // Line of the outstanding request; instr may move on while waiting
  assign reqIdx = cur_ff.reqAddr[BLK_BITS+:IDX_BITS];
  // Next-state for the block operation sequencer
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    nxt_ff.dsi = 1'b0;
    nxt_ff.priv = 1'b0;
    nxt_ff.mchk = 1'b0;
    nxt_ff.rc = 1'b0;
    // R2 delayed machine check for allocated block
    // Checked first so a new allocation in the same cycle stays pending
    if (busErr && cur_ff.allocPend) begin
      nxt_ff.mchk = 1'b1;
      nxt_ff.allocPend = 1'b0;
      nxt_ff.valid[cur_ff.allocIdx] = 1'b0;
    end
    case (cur_ff.st)
      DCBO_IDLE: begin
        if (issue && op != DCBO_OP_NONE) begin
          nxt_ff.reqAddr = {addr[31:BLK_BITS], {BLK_BITS{1'b0}}};
          nxt_ff.reqCoh = coherent;
          nxt_ff.done = 1'b1;
          case (op)
            DCBO_OP_FLUSH: begin
              // R11 load-style check, attributes ignored
              if (dataTranslationEnable && (!xlateHit || !protOk)) begin
                nxt_ff.dsi = 1'b1;
              end else if (mod) begin
                // R8 R10 writeback then invalidate
                nxt_ff.reqValid = 1'b1;
                nxt_ff.reqCmd = DCBO_BUS_WRBACK;
                nxt_ff.killAfter = 1'b1;
                nxt_ff.done = 1'b0;
                nxt_ff.busy = 1'b1;
                nxt_ff.st = DCBO_WAIT;
              end else begin
                if (hit) begin
                  nxt_ff.valid[idx] = 1'b0;
                end
                // R7 address-only broadcast when coherent
                if (coherent) begin
                  nxt_ff.reqValid = 1'b1;
                  nxt_ff.reqCmd = DCBO_BUS_FLUSH;
                  nxt_ff.done = 1'b0;
                  nxt_ff.busy = 1'b1;
                  nxt_ff.st = DCBO_WAIT;
                end
              end
            end
            DCBO_OP_INVAL: begin
              // R16 supervisor only
              if (userMode) begin
                nxt_ff.priv = 1'b1;
              // R14 R15 store-style check
              end else if (dataTranslationEnable && (!xlateHit || !protOk)) begin
                nxt_ff.dsi = 1'b1;
              end else begin
                // R12 drop dirty data unwritten
                if (hit) begin
                  nxt_ff.valid[idx] = 1'b0;
                  nxt_ff.dirty[idx] = 1'b0;
                end
                nxt_ff.rc = 1'b1;
                if (coherent) begin
                  nxt_ff.reqValid = 1'b1;
                  nxt_ff.reqCmd = DCBO_BUS_KILL;
                  nxt_ff.done = 1'b0;
                  nxt_ff.busy = 1'b1;
                  nxt_ff.st = DCBO_WAIT;
                end
              end
            end
            DCBO_OP_CLEAN: begin
              // R19 load-style check
              if (dataTranslationEnable && (!xlateHit || !protOk)) begin
                nxt_ff.dsi = 1'b1;
              // R18 write back modified block
              end else if (mod) begin
                nxt_ff.reqValid = 1'b1;
                nxt_ff.reqCmd = DCBO_BUS_WRBACK;
                nxt_ff.killAfter = 1'b0;
                nxt_ff.done = 1'b0;
                nxt_ff.busy = 1'b1;
                nxt_ff.st = DCBO_WAIT;
              // R17 coherent: only signal others
              end else if (coherent) begin
                nxt_ff.reqValid = 1'b1;
                nxt_ff.reqCmd = DCBO_BUS_CLEAN;
                nxt_ff.done = 1'b0;
                nxt_ff.busy = 1'b1;
                nxt_ff.st = DCBO_WAIT;
              end
            end
            DCBO_OP_ALLOC: begin
              // R1 zero fill new block
              if (!cacheInhibit && !hit && !(dataTranslationEnable && !xlateHit)) begin
                nxt_ff.valid[idx] = 1'b1;
                nxt_ff.dirty[idx] = 1'b1;
                nxt_ff.tag[idx] = tg;
                nxt_ff.word0[idx] = ZERO_FILL;
                nxt_ff.allocPend = 1'b1;
                nxt_ff.allocIdx = idx;
              end
            end
            // R20 R21 R22 R23 touch hints ignored, no fault
            default: nxt_ff.done = 1'b1;
          endcase
        end
      end
      DCBO_WAIT: begin
        if (link.ackValid) begin
          nxt_ff.reqValid = 1'b0;
          nxt_ff.reqCmd = DCBO_BUS_NONE;
          nxt_ff.busy = 1'b0;
          nxt_ff.done = 1'b1;
          nxt_ff.st = DCBO_IDLE;
          // R18 block left clean; valid cleared too when killAfter is set (flush)
          if (cur_ff.reqCmd == DCBO_BUS_WRBACK) begin
            nxt_ff.dirty[reqIdx] = 1'b0;
            if (cur_ff.killAfter) begin
              nxt_ff.valid[reqIdx] = 1'b0;
            end
          end
        end
      end
      default: nxt_ff.st = DCBO_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
  assign busy = cur_ff.busy;
  assign done = cur_ff.done;
  assign dsiExc = cur_ff.dsi;
  assign privExc = cur_ff.priv;
  assign machineCheck = cur_ff.mchk;
  assign refChgSet = cur_ff.rc;
  assign link.reqValid = cur_ff.reqValid;
  assign link.reqCmd = cur_ff.reqCmd;
  assign link.reqAddr = cur_ff.reqAddr;
  assign link.reqCoherent = cur_ff.reqCoh;
endmodule : dcbo_core_end

// file: core/dcbo_decode.sv
`timescale 1ns/1ps
module dcbo_decode (
  input wire logic [31:0] instr,
  input wire logic [31:0] firstIndexReg,
  input wire logic [31:0] secondIndexReg,
  output dcbo_pkg::dcbo_op_t op,
  output logic [31:0] targetAddr
);
  import dcbo_pkg::*;
  logic [31:0] masked;
  assign masked = instr & OP_MASK;
  // R4 R5 R6 fixed encodings
  always_comb begin
    case (masked)
      OP_FLUSH: op = DCBO_OP_FLUSH;
      OP_INVAL: op = DCBO_OP_INVAL;
      OP_CLEAN: op = DCBO_OP_CLEAN;
      OP_ALLOC: op = DCBO_OP_ALLOC;
      OP_TOUCH, OP_TOUCHST: op = DCBO_OP_TOUCH;
      default: op = DCBO_OP_NONE;
    endcase
  end
  // R3 base zero when field zero
  assign targetAddr = ((instr[RA_LSB+:5] == 5'h00) ? 32'h00000000 : firstIndexReg)
    + secondIndexReg;
endmodule : dcbo_decode

// file: core/dcbo_link_if.sv
`timescale 1ns/1ps
interface dcbo_link_if;
  import dcbo_pkg::*;
  // Request from the core's cache to memory and other caches
  logic reqValid;
  dcbo_bus_t reqCmd;
  logic [31:0] reqAddr;
  logic reqCoherent;
  // Completion from the far side
  logic ackValid;
  logic snoopHitMod;
  modport core (output reqValid, output reqCmd, output reqAddr, output reqCoherent,
    input ackValid, input snoopHitMod);
  modport system (input reqValid, input reqCmd, input reqAddr, input reqCoherent,
    output ackValid, output snoopHitMod);
endinterface : dcbo_link_if

// file: core/dcbo_pkg.sv
package dcbo_pkg;
  // Instruction encodings with register fields masked off
  localparam logic [31:0] OP_FLUSH = 32'h7C0000AC;
  localparam logic [31:0] OP_INVAL = 32'h7C0003AC;
  localparam logic [31:0] OP_CLEAN = 32'h7C00006C;
  localparam logic [31:0] OP_ALLOC = 32'h7C0005EC;
  localparam logic [31:0] OP_TOUCH = 32'h7C00022C;
  localparam logic [31:0] OP_TOUCHST = 32'h7C0001EC;
  localparam logic [31:0] OP_MASK = 32'hFC0007FE;
  // Register field positions
  localparam int RA_LSB = 16;
  localparam int RB_LSB = 11;
  // Cache geometry
  localparam int BLK_BITS = 5;
  localparam int IDX_BITS = 3;
  localparam int DATA_W = 32;
  // Bus command codes
  typedef enum logic [2:0] {
    DCBO_BUS_NONE,
    DCBO_BUS_FLUSH,
    DCBO_BUS_KILL,
    DCBO_BUS_CLEAN,
    DCBO_BUS_WRBACK
  } dcbo_bus_t;
  typedef enum logic [2:0] {
    DCBO_OP_NONE,
    DCBO_OP_FLUSH,
    DCBO_OP_INVAL,
    DCBO_OP_CLEAN,
    DCBO_OP_ALLOC,
    DCBO_OP_TOUCH
  } dcbo_op_t;
  localparam logic [DATA_W-1:0] ZERO_FILL = 32'h00000000;
endpackage : dcbo_pkg

// file: core/dcbo_system_end.sv
`timescale 1ns/1ps
module dcbo_system_end (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic peerHoldsMod,
  input wire logic peerHoldsCopy,
  output logic memWrite,
  output logic peerInvalidate,
  output logic [31:0] memAddr,
  dcbo_link_if.system link
);
  import dcbo_pkg::*;
  typedef struct packed {
    logic ack;
    logic hitMod;
    logic memWr;
    logic peerInv;
    logic [31:0] addr;
  } dcbo_sys_t;
  dcbo_sys_t cur_ff;
  dcbo_sys_t nxt_ff;
  // One-cycle answer to each request
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = 1'b0;
    nxt_ff.memWr = 1'b0;
    nxt_ff.peerInv = 1'b0;
    nxt_ff.hitMod = 1'b0;
    if (link.reqValid && !cur_ff.ack) begin
      nxt_ff.ack = 1'b1;
      nxt_ff.addr = link.reqAddr;
      nxt_ff.hitMod = peerHoldsMod;
      case (link.reqCmd)
        // R9 peer writes back then invalidates
        DCBO_BUS_FLUSH: begin
          nxt_ff.memWr = peerHoldsMod;
          nxt_ff.peerInv = peerHoldsMod || peerHoldsCopy;
        end
        // R12 R13 invalidate without writeback
        DCBO_BUS_KILL: nxt_ff.peerInv = peerHoldsMod || peerHoldsCopy;
        // R17 peer writes modified copy
        DCBO_BUS_CLEAN: nxt_ff.memWr = peerHoldsMod;
        DCBO_BUS_WRBACK: nxt_ff.memWr = 1'b1;
        default: nxt_ff.memWr = 1'b0;
      endcase
    end
  end
  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
  assign link.ackValid = cur_ff.ack;
  assign link.snoopHitMod = cur_ff.hitMod;
  assign memWrite = cur_ff.memWr;
  assign peerInvalidate = cur_ff.peerInv;
  assign memAddr = cur_ff.addr;
endmodule : dcbo_system_end

// file: verification/dcbo_link_asserts.sv
`timescale 1ns/1ps
module dcbo_link_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire dcbo_pkg::dcbo_bus_t reqCmd,
  input wire logic [31:0] reqAddr,
  input wire logic reqCoherent,
  input wire logic ackValid,
  input wire logic snoopHitMod
);
  import dcbo_pkg::*;
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_addr_aligned: assert property (reqValid |-> reqAddr[4:0] == 5'h00)
    else $error("request address not block aligned");
  a_req_holds: assert property (reqValid && !ackValid |=> reqValid && $stable(reqAddr))
    else $error("request changed before acknowledge");
  a_cmd_holds: assert property (reqValid && !ackValid |=> $stable(reqCmd))
    else $error("request command changed before acknowledge");
  a_ack_prompt: assert property ($rose(reqValid) |=> ackValid)
    else $error("far side did not answer one cycle later");
  a_ack_pulse: assert property (ackValid |=> !ackValid)
    else $error("acknowledge longer than one cycle");
  a_req_release: assert property (ackValid |=> !reqValid)
    else $error("request not released after acknowledge");
  a_local_only: assert property (reqValid && !reqCoherent |-> reqCmd == DCBO_BUS_WRBACK)
    else $error("broadcast on non-coherent block");
  a_cmd_known: assert property (reqValid |-> reqCmd != DCBO_BUS_NONE)
    else $error("request without a command");
  a_ack_has_req: assert property (ackValid |-> reqValid)
    else $error("acknowledge without request");
  a_snoop_ack: assert property (snoopHitMod |-> ackValid)
    else $error("snoop result outside an acknowledge");
  // Main traffic kinds seen
  c_kill: cover property (reqValid && reqCmd == DCBO_BUS_KILL);
  c_clean: cover property (reqValid && reqCmd == DCBO_BUS_CLEAN);
  c_wrback: cover property (ackValid && reqCmd == DCBO_BUS_WRBACK);
endmodule : dcbo_link_asserts

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dcbo_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic issue = 1'b0;
  logic [31:0] instr = 32'h00000000;
  logic [31:0] firstIndexReg = 32'h00000000;
  logic [31:0] secondIndexReg = 32'h00000000;
  logic coherent = 1'b0;
  logic cacheInhibit = 1'b0;
  logic userMode = 1'b0;
  logic dataTranslationEnable = 1'b0;
  logic xlateHit = 1'b1;
  logic protOk = 1'b1;
  logic busErr = 1'b0;
  logic peerHoldsMod = 1'b0;
  logic peerHoldsCopy = 1'b0;
  logic busy, done, dsiExc, privExc, machineCheck, refChgSet, memWrite, peerInvalidate;
  logic [31:0] memAddr, addr, mAddr;
  logic sReq, sMem, sInv, sDsi, sPriv, sRc, sBusy, sFin;
  dcbo_bus_t cmd;
  int miscompares = 0;
  int n_tests = 0;

  always #20 clk_sys = ~clk_sys;

  dcbo_link_if dcbo_link_if_i ();
  dcbo_core_end dcbo_core_end_i (.clk_sys, .rst_b, .issue, .instr, .firstIndexReg,
    .secondIndexReg, .coherent, .cacheInhibit, .userMode, .dataTranslationEnable, .xlateHit,
    .protOk, .busErr, .busy, .done, .dsiExc, .privExc, .machineCheck, .refChgSet,
    .link(dcbo_link_if_i.core));
  dcbo_system_end dcbo_system_end_i (.clk_sys, .rst_b, .peerHoldsMod, .peerHoldsCopy,
    .memWrite, .peerInvalidate, .memAddr, .link(dcbo_link_if_i.system));
  dcbo_link_asserts dcbo_link_asserts_i (.clk_sys, .rst_b,
    .reqValid(dcbo_link_if_i.reqValid), .reqCmd(dcbo_link_if_i.reqCmd),
    .reqAddr(dcbo_link_if_i.reqAddr), .reqCoherent(dcbo_link_if_i.reqCoherent),
    .ackValid(dcbo_link_if_i.ackValid), .snoopHitMod(dcbo_link_if_i.snoopHitMod));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Issue one op, mode is {coherent, user, translate, hit}; gather what comes back
  task automatic run(input logic [31:0] op, input logic [4:0] ra, input logic [31:0] b,
      input logic [3:0] mode);
    @(negedge clk_sys);
    {coherent, userMode, dataTranslationEnable, xlateHit} = mode;
    instr = op | {11'h000, ra, 5'h04, 11'h000};
    firstIndexReg = 32'h00002000;
    secondIndexReg = b;
    issue = 1'b1;
    {sReq, sMem, sInv, sDsi, sPriv, sRc, sBusy, sFin} = 8'h00;
    // Clear what the last op left so a silent op cannot pass on stale values
    cmd = DCBO_BUS_NONE;
    addr = 32'h00000000;
    mAddr = 32'h00000000;
    @(negedge clk_sys);
    issue = 1'b0;
    repeat (12) begin
      if (dcbo_link_if_i.reqValid === 1'b1) begin
        sReq = 1'b1;
        cmd = dcbo_link_if_i.reqCmd;
        addr = dcbo_link_if_i.reqAddr;
      end
      if (memWrite === 1'b1) begin
        sMem = 1'b1;
        mAddr = memAddr;
      end
      sInv |= peerInvalidate === 1'b1;
      sRc |= refChgSet === 1'b1;
      sDsi |= dsiExc === 1'b1;
      sPriv |= privExc === 1'b1;
      sBusy |= busy === 1'b1;
      sFin = done === 1'b1 || sDsi || sPriv;
      if (sFin) break;
      @(negedge clk_sys);
    end
    chk("op finished", 1, sFin);
  endtask : run

  // Dirty allocated block written back; zero base field ignores first operand
  task automatic alloc_flush();
    run(OP_ALLOC, 5'h00, 32'h00001234, 4'h1);
    run(OP_FLUSH, 5'h00, 32'h00001234, 4'h1);
    chk("flush cmd", DCBO_BUS_WRBACK, 32'(cmd));
    chk("flush memw", 1, sMem);
    chk("flush addr", 32'h00001220, mAddr);
    run(OP_FLUSH, 5'h00, 32'h00001234, 4'h1);
    chk("absent req", 0, sReq);
    run(OP_ALLOC, 5'h00, 32'h00001234, 4'h1);
    run(OP_CLEAN, 5'h00, 32'h00001234, 4'h1);
    chk("clean wb cmd", DCBO_BUS_WRBACK, 32'(cmd));
    chk("clean wb memw", 1, sMem);
    run(OP_CLEAN, 5'h00, 32'h00001234, 4'h1);
    chk("clean again req", 0, sReq);
    run(OP_ALLOC, 5'h00, 32'h00005000, 4'h1);
    @(negedge clk_sys);
    busErr = 1'b1;
    sRc = 1'b0;
    repeat (4) begin
      @(negedge clk_sys);
      sRc |= machineCheck === 1'b1;
    end
    busErr = 1'b0;
    chk("mcheck", 1, sRc);
  endtask : alloc_flush

  // Privilege and translation faults stop invalidate, and a protection fault stops flush, before the bus
  task automatic inval_faults();
    run(OP_INVAL, 5'h03, 32'h00000040, 4'h5);
    chk("user priv", 1, sPriv);
    chk("user req", 0, sReq);
    chk("user busy", 0, sBusy);
    run(OP_INVAL, 5'h03, 32'h00000040, 4'h2);
    chk("xlate dsi", 1, sDsi);
    // Translated but protection refused, as a store and as a load
    protOk = 1'b0;
    run(OP_INVAL, 5'h03, 32'h00000040, 4'h3);
    chk("prot dsi", 1, sDsi);
    run(OP_FLUSH, 5'h03, 32'h00000040, 4'h3);
    chk("flush prot dsi", 1, sDsi);
    protOk = 1'b1;
  endtask : inval_faults

  // Coherent traffic, then one non-coherent clean, with a peer holding a dirty copy
  task automatic coherent_ops();
    peerHoldsMod = 1'b1;
    peerHoldsCopy = 1'b1;
    run(OP_INVAL, 5'h03, 32'h00000050, 4'h9);
    chk("kill cmd", DCBO_BUS_KILL, 32'(cmd));
    chk("kill addr", 32'h00002040, addr);
    chk("kill inv", 1, sInv);
    chk("kill memw", 0, sMem);
    chk("kill rc", 1, sRc);
    chk("kill busy", 1, sBusy);
    run(OP_CLEAN, 5'h00, 32'h00003000, 4'h9);
    chk("clean cmd", DCBO_BUS_CLEAN, 32'(cmd));
    chk("clean memw", 1, sMem);
    run(OP_FLUSH, 5'h00, 32'h00003000, 4'h9);
    chk("bcast req", 1, sReq);
    chk("bcast inv", 1, sInv);
    run(OP_CLEAN, 5'h00, 32'h00003000, 4'h1);
    chk("local clean", 0, sReq);
    peerHoldsMod = 1'b0;
    peerHoldsCopy = 1'b0;
  endtask : coherent_ops

  // Touch hints, inhibited and faulting, stay silent
  task automatic touches();
    cacheInhibit = 1'b1;
    run(OP_TOUCH, 5'h00, 32'h00004000, 4'h2);
    chk("touch dsi", 0, sDsi);
    chk("touch req", 0, sReq);
    run(OP_TOUCHST, 5'h00, 32'h00004003, 4'h2);
    chk("touchst dsi", 0, sDsi);
    chk("touchst req", 0, sReq);
    cacheInhibit = 1'b0;
  endtask : touches

  // Hang guard, well beyond the few dozen cycles of the tests
  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    alloc_flush();
    inval_faults();
    coherent_ops();
    touches();
    summarize();
  end
endmodule : testbench
